// ---- verilog/fcr_pkg.sv ----
// Purpose: Shared constants of the flash configuration register block
// Assumes: Eight-bit opcodes, MSB first on a single data line
// Notes:   Function register and read parameters live in fcr_top
package fcr_pkg;

   // ----------------------------------------------------------------
   // Register fields and reset values
   // ----------------------------------------------------------------
   localparam int        PROTECT_REGION_END_SELECT_BIT = 1;
   localparam int        PROGRAM_SUSPENDED_FLAG_BIT    = 2;
   localparam int        ERASE_SUSPENDED_FLAG_BIT      = 3;
   localparam int        INFO_ROW_LOCK_0_BIT           = 4;
   localparam logic [7:0] FUNC_RESET                   = 8'h00;
   localparam logic [7:0] FUNC_WRITE_MASK              = 8'hf2;
   localparam logic [7:0] READ_PARAM_RESET             = 8'he0;
   localparam int        DRIVE_HI = 7;
   localparam int        DRIVE_LO = 5;
   localparam int        DUMMY_HI = 4;
   localparam int        DUMMY_LO = 3;
   localparam int        WRAP_BIT = 2;
   localparam int        BURST_HI = 1;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] WRITE_ENABLE_CMD    = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_OP    = 8'h04;
   localparam logic [7:0] WRITE_STATUS_CMD    = 8'h01;
   localparam logic [7:0] WRITE_FUNC_OP       = 8'h42;
   localparam logic [7:0] SET_READ_PARAMS_CMD = 8'hc0;
   localparam logic [7:0] SUSPEND_OP          = 8'h75;
   localparam logic [7:0] RESUME_OP           = 8'h7a;
   localparam logic [7:0] READ_NORMAL_OP      = 8'h03;
   localparam logic [7:0] READ_FAST_OP        = 8'h0b;
   localparam logic [7:0] READ_DUAL_OUT_OP    = 8'h3b;
   localparam logic [7:0] READ_DUAL_IO_OP     = 8'hbb;
   localparam logic [7:0] READ_QUAD_IO_OP     = 8'heb;

   // ----------------------------------------------------------------
   // Decode tables
   // ----------------------------------------------------------------
   localparam logic [3:0] DUMMY_FIXED = 4'h8;
   localparam logic [3:0] DUMMY_QUAD [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
   localparam logic [3:0] DUMMY_DUAL [4] = '{4'h4, 4'h4, 4'h8, 4'h4};
   localparam logic [3:0] DRIVE_EIGHTHS [8] =
      '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
   localparam logic [6:0] BURST_MIN_BYTES = 7'h08;
   localparam logic [4:0] LINK_OP_LAST    = 5'h07;
   localparam logic [4:0] LINK_DATA_LAST  = 5'h0f;
   localparam logic [4:0] LINK_CNT_SAT    = 5'h10;

endpackage

// ---- verilog/fcr_cmd_if.sv ----
// Purpose: Carries a received command from the link domain to the core
// Assumes: opcode and data settle before toggle flips
// Notes:   toggle is the only signal that needs synchronising
`timescale 1ns/10ps
interface fcr_cmd_if;
   logic       toggle;
   logic [7:0] opcode;
   logic [7:0] data;
   modport link (output toggle, output opcode, output data);
   modport core (input toggle, input opcode, input data);
endinterface

// ---- verilog/fcr_sync2.sv ----
// Purpose: Two-flop synchroniser for slow levels and toggles
// Assumes: Input changes slower than the destination clock
// Notes:   First stage feeds the second stage only
`timescale 1ns/10ps
module fcr_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } fcr_sync_s;
   fcr_sync_s s, next_s;

   always_comb begin
      next_s.first  = d;
      next_s.second = s.first;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) s <= '0;
      else        s <= next_s;
   end

   assign q = s.second;
endmodule

// ---- verilog/fcr_link_rx.sv ----
// Purpose: Shifts commands in on the serial clock and hands them over
// Assumes: Mode 0 sampling, MSB first, one command per frame
// Notes:   Frame state is cleared by the chip-select itself
`timescale 1ns/10ps
module fcr_link_rx
   import fcr_pkg::*;
(
   // Link pins
   input  wire logic lnk_sck,
   input  wire logic lnk_cs_n,
   input  wire logic lnk_si,
   // Reset
   input  wire logic rst_n,
   // Handover
   fcr_cmd_if.link   cmd
);
   typedef struct packed {
      logic [4:0]  cnt;
      logic [15:0] shift;
   } fcr_frame_s;
   typedef struct packed {
      logic       toggle;
      logic [7:0] opcode;
      logic [7:0] data;
   } fcr_hold_s;

   fcr_frame_s f, next_f;
   fcr_hold_s  h, next_h;
   logic [15:0] word;

   // ----------------------------------------------------------------
   // Shift and capture
   // ----------------------------------------------------------------
   always_comb begin
      word   = {f.shift[14:0], lnk_si};
      next_f = f;
      next_h = h;
      next_f.shift = word;
      if (f.cnt != LINK_CNT_SAT) next_f.cnt = f.cnt + 5'h01;
      if (f.cnt == LINK_OP_LAST) begin
         case (word[7:0])
            WRITE_ENABLE_CMD, WRITE_DISABLE_OP,
            SUSPEND_OP, RESUME_OP: begin
               next_h.toggle = ~h.toggle;
               next_h.opcode = word[7:0];
               next_h.data   = 8'h00;
            end
            default: ;
         endcase
      end
      if (f.cnt == LINK_DATA_LAST) begin
         case (word[15:8])
            WRITE_STATUS_CMD, WRITE_FUNC_OP, SET_READ_PARAMS_CMD: begin
               next_h.toggle = ~h.toggle;
               next_h.opcode = word[15:8];
               next_h.data   = word[7:0];
            end
            default: ;
         endcase
      end
   end

   // Serial clock may stop between frames, so chip-select clears it
   always_ff @(posedge lnk_sck or posedge lnk_cs_n) begin
      if (lnk_cs_n) f <= '0;
      else          f <= next_f;
   end

   always_ff @(posedge lnk_sck or negedge rst_n) begin
      if (!rst_n) h <= '0;
      else        h <= next_h;
   end

   assign cmd.toggle = h.toggle;
   assign cmd.opcode = h.opcode;
   assign cmd.data   = h.data;
endmodule

// ---- verilog/fcr_top.sv ----
// Purpose: Function and read parameter registers of a serial flash
// Assumes: Array engine and read path run on ref_clk
// Notes:   Non-volatile bits start from their reset value here
`timescale 1ns/10ps
module fcr_top
   import fcr_pkg::*;
#(
   parameter int BLOCKS = 256
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   // Serial link
   input  wire logic                        lnk_sck,
   input  wire logic                        lnk_cs_n,
   input  wire logic                        lnk_si,
   // Write-protect pin and status register view
   input  wire logic                        wp_n,
   input  wire logic [3:0]                  status_bp,
   input  wire logic                        status_write_disable,
   // Array engine
   input  wire logic                        program_busy,
   input  wire logic                        erase_busy,
   input  wire logic                        ir_program_req,
   input  wire logic [1:0]                  ir_program_row,
   output logic                             ir_program_grant,
   // Read path
   input  wire logic [7:0]                  rd_opcode,
   input  wire logic                        qpi_mode,
   input  wire logic                        dtr_mode,
   input  wire logic [23:0]                 addr_cur,
   output logic      [3:0]                  dummy_cycles,
   output logic      [23:0]                 addr_next,
   // Register views
   output logic      [7:0]                  function_config,
   output logic      [7:0]                  read_parameters,
   output logic                             write_enable_latch,
   output logic      [3:0]                  drive_eighths,
   output logic                             drive_reserved,
   output logic      [6:0]                  burst_bytes,
   // Block protection
   output logic                             prot_any,
   output logic      [$clog2(BLOCKS)-1:0]   prot_lo,
   output logic      [$clog2(BLOCKS)-1:0]   prot_hi,
   // Status register write
   output logic                             status_write_pulse,
   output logic      [7:0]                  status_write_data
);
   localparam int BW = $clog2(BLOCKS);

   if (BLOCKS < 2 || BLOCKS > 256 ||
       (BLOCKS & (BLOCKS - 1)) != 0) begin : g_chk
      $error("BLOCKS must be a power of two from 2 to 256");
   end

   typedef struct packed {
      logic [7:0]  func;
      logic [7:0]  rdp;
      logic        we_latch;
      logic        st_pulse;
      logic [7:0]  st_data;
      logic [3:0]  dummy;
      logic [3:0]  drive;
      logic        drv_rsv;
      logic [6:0]  burst;
      logic [23:0] addr;
      logic        pany;
      logic [BW-1:0] plo;
      logic [BW-1:0] phi;
      logic        ir_grant;
      logic        tog_prev;
   } fcr_state_s;

   fcr_state_s s, next_s;

   // ----------------------------------------------------------------
   // Link and crossings
   // ----------------------------------------------------------------
   fcr_cmd_if cmd ();
   logic      tog_s;
   logic      wp_n_s;
   logic      evt;
   logic      wp_low;

   fcr_link_rx u_link (
      .lnk_sck  (lnk_sck),
      .lnk_cs_n (lnk_cs_n),
      .lnk_si   (lnk_si),
      .rst_n    (rst_n),
      .cmd      (cmd.link)
   );

   fcr_sync2 #(.W(2)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .d       ({cmd.toggle, wp_n}),
      .q       ({tog_s, wp_n_s})
   );

   // Opcode and data held steady since before the toggle moved
   assign evt    = tog_s != s.tog_prev;
   assign wp_low = ~wp_n_s;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [BW:0]   n_blk;
   logic [1:0]    dsel;
   logic [23:0]   win;
   logic [2:0]    dcode;

   always_comb begin
      next_s          = s;
      next_s.tog_prev = tog_s;
      next_s.st_pulse = 1'b0;
      dsel  = s.rdp[DUMMY_HI:DUMMY_LO];
      dcode = s.rdp[DRIVE_HI:DRIVE_LO];

      if (evt) begin
         case (cmd.opcode)
            WRITE_ENABLE_CMD: next_s.we_latch = 1'b1;
            WRITE_DISABLE_OP: next_s.we_latch = 1'b0;
            WRITE_STATUS_CMD: begin
               // Pin low plus disable bit locks the status bits
               if (s.we_latch &&
                   !(status_write_disable && wp_low)) begin
                  next_s.st_pulse = 1'b1;
                  next_s.st_data  = cmd.data;
                  next_s.we_latch = 1'b0;
               end
            end
            WRITE_FUNC_OP: begin
               if (s.we_latch) begin
                  // Bits only ever go from zero to one
                  next_s.func = s.func |
                                (cmd.data & FUNC_WRITE_MASK);
                  next_s.we_latch = 1'b0;
               end
            end
            SET_READ_PARAMS_CMD: next_s.rdp = cmd.data;
            SUSPEND_OP: begin
               if (program_busy)
                  next_s.func[PROGRAM_SUSPENDED_FLAG_BIT] = 1'b1;
               else if (erase_busy)
                  next_s.func[ERASE_SUSPENDED_FLAG_BIT] = 1'b1;
            end
            RESUME_OP: begin
               // A program suspended inside an erase suspend resumes first
               if (s.func[PROGRAM_SUSPENDED_FLAG_BIT])
                  next_s.func[PROGRAM_SUSPENDED_FLAG_BIT] = 1'b0;
               else
                  next_s.func[ERASE_SUSPENDED_FLAG_BIT] = 1'b0;
            end
            default: ;
         endcase
      end

      // Info row lock check
      next_s.ir_grant = ir_program_req &&
         !s.func[INFO_ROW_LOCK_0_BIT + int'(ir_program_row)];

      // Dummy cycles include mode-bit cycles
      case (rd_opcode)
         READ_NORMAL_OP:   next_s.dummy = 4'h0;
         READ_FAST_OP:     next_s.dummy = qpi_mode ? DUMMY_QUAD[dsel]
                                                   : DUMMY_FIXED;
         READ_DUAL_OUT_OP: next_s.dummy = DUMMY_FIXED;
         READ_DUAL_IO_OP:  next_s.dummy = DUMMY_DUAL[dsel];
         READ_QUAD_IO_OP:  next_s.dummy = DUMMY_QUAD[dsel];
         default:          next_s.dummy = 4'h0;
      endcase
      if (dtr_mode) next_s.dummy = next_s.dummy >> 1;

      // Drive strength
      next_s.drive   = DRIVE_EIGHTHS[dcode];
      next_s.drv_rsv = (dcode == 3'h0) || (dcode == 3'h4);

      // Burst and wrap
      next_s.burst = BURST_MIN_BYTES << s.rdp[BURST_HI:0];
      win = {17'h00000, s.burst} - 24'h000001;
      if (s.rdp[WRAP_BIT])
         next_s.addr = (addr_cur & ~win) |
                       ((addr_cur + 24'h000001) & win);
      else
         next_s.addr = addr_cur + 24'h000001;

      // Protected block range
      if (status_bp == 4'h0) begin
         n_blk = '0;
      end else if (int'(status_bp) - 1 >= BW) begin
         n_blk = (BW+1)'(BLOCKS);
      end else begin
         n_blk = (BW+1)'(1) << (status_bp - 4'h1);
      end
      next_s.pany = status_bp != 4'h0;
      if (s.func[PROTECT_REGION_END_SELECT_BIT]) begin
         next_s.plo = '0;
         next_s.phi = BW'(n_blk - (BW+1)'(1));
      end else begin
         next_s.plo = BW'((BW+1)'(BLOCKS) - n_blk);
         next_s.phi = BW'(BLOCKS - 1);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s       <= '0;
         s.func  <= FUNC_RESET;
         s.rdp   <= READ_PARAM_RESET;
         s.burst <= BURST_MIN_BYTES;
         s.drive <= DRIVE_EIGHTHS[3'h7];
         s.plo   <= '0;
         s.phi   <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign function_config    = s.func;
   assign read_parameters    = s.rdp;
   assign write_enable_latch = s.we_latch;
   assign status_write_pulse = s.st_pulse;
   assign status_write_data  = s.st_data;
   assign dummy_cycles       = s.dummy;
   assign drive_eighths      = s.drive;
   assign drive_reserved     = s.drv_rsv;
   assign burst_bytes        = s.burst;
   assign addr_next          = s.addr;
   assign prot_any           = s.pany;
   assign prot_lo            = s.plo;
   assign prot_hi            = s.phi;
   assign ir_program_grant   = s.ir_grant;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_bottom;
      (status_bp != 4'h0 && s.func[PROTECT_REGION_END_SELECT_BIT])
         |=> (prot_lo == '0);
   endproperty
   a_bottom: assert property (p_bottom) else
      $error("bottom protection does not start at block zero");

   property p_top;
      (status_bp != 4'h0 && !s.func[PROTECT_REGION_END_SELECT_BIT])
         |=> (prot_hi == BW'(BLOCKS - 1));
   endproperty
   a_top: assert property (p_top) else
      $error("top protection does not end at last block");

   property p_prog_susp;
      (evt && cmd.opcode == SUSPEND_OP && program_busy)
         |=> function_config[PROGRAM_SUSPENDED_FLAG_BIT];
   endproperty
   a_prog_susp: assert property (p_prog_susp) else
      $error("program suspend flag not set");

   property p_erase_susp;
      (evt && cmd.opcode == SUSPEND_OP && !program_busy && erase_busy)
         |=> function_config[ERASE_SUSPENDED_FLAG_BIT];
   endproperty
   a_erase_susp: assert property (p_erase_susp) else
      $error("erase suspend flag not set");

   property p_lock;
      (ir_program_req &&
       function_config[INFO_ROW_LOCK_0_BIT + int'(ir_program_row)])
         |=> !ir_program_grant;
   endproperty
   a_lock: assert property (p_lock) else
      $error("locked info row granted");

   property p_otp;
      ((($past(function_config) & ~function_config)
        & FUNC_WRITE_MASK) == 8'h00);
   endproperty
   a_otp: assert property (p_otp) else
      $error("one-time bit returned to zero");

   property p_rsv;
      function_config[0] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv) else
      $error("reserved function bit set");

   property p_set_params;
      (evt && cmd.opcode == SET_READ_PARAMS_CMD)
         |=> (read_parameters == $past(cmd.data));
   endproperty
   a_set_params: assert property (p_set_params) else
      $error("read parameters not loaded");

   property p_burst;
      ##1 (burst_bytes == (BURST_MIN_BYTES << $past(s.rdp[BURST_HI:0])));
   endproperty
   a_burst: assert property (p_burst) else
      $error("burst length decode wrong");

   property p_linear;
      !s.rdp[WRAP_BIT] |=> (addr_next == $past(addr_cur) + 24'h000001);
   endproperty
   a_linear: assert property (p_linear) else
      $error("linear read did not advance");

   property p_normal;
      (rd_opcode == READ_NORMAL_OP) |=> (dummy_cycles == 4'h0);
   endproperty
   a_normal: assert property (p_normal) else
      $error("normal read has dummy cycles");

   property p_dual_out;
      (rd_opcode == READ_DUAL_OUT_OP && !dtr_mode)
         |=> (dummy_cycles == 4'h8);
   endproperty
   a_dual_out: assert property (p_dual_out) else
      $error("dual output dummy count wrong");

   property p_quad;
      (rd_opcode == READ_QUAD_IO_OP && !dtr_mode && dsel == 2'h3)
         |=> (dummy_cycles == 4'ha);
   endproperty
   a_quad: assert property (p_quad) else
      $error("quad dummy count wrong");

   property p_dual_io;
      (rd_opcode == READ_DUAL_IO_OP && dtr_mode && dsel == 2'h2)
         |=> (dummy_cycles == 4'h4);
   endproperty
   a_dual_io: assert property (p_dual_io) else
      $error("dual io dummy count wrong");

   property p_drive;
      (s.rdp[DRIVE_HI:DRIVE_LO] == 3'h5) |=> (drive_eighths == 4'h6);
   endproperty
   a_drive: assert property (p_drive) else
      $error("drive decode wrong");

   property p_wp;
      (evt && cmd.opcode == WRITE_STATUS_CMD && status_write_disable
       && wp_low) |=> !status_write_pulse [*2];
   endproperty
   a_wp: assert property (p_wp) else
      $error("protected status write went through");

   property p_need_enable;
      (evt && cmd.opcode == WRITE_FUNC_OP && !write_enable_latch)
         |=> $stable(function_config);
   endproperty
   a_need_enable: assert property (p_need_enable) else
      $error("function write without write enable");

   c_set_prm:  cover property (evt && cmd.opcode == SET_READ_PARAMS_CMD);
   c_st_write: cover property (status_write_pulse);
   c_susp:   cover property (function_config[PROGRAM_SUSPENDED_FLAG_BIT]
                             && function_config[ERASE_SUSPENDED_FLAG_BIT]);
   c_wrap:   cover property (s.rdp[WRAP_BIT] && addr_next[2:0] == 3'h0);
endmodule

// ---- dv/fcr_host.sv ----
// Purpose: Host side of the serial link, sends command frames
// Assumes: Mode 0, MSB first, clock stands still between frames
// Notes:   Data line shows the inverse of its last bit when deselected
`timescale 1ns/10ps
module fcr_host (
   // Link pins
   output logic lnk_sck,
   output logic lnk_cs_n,
   output logic lnk_si
);
   initial begin
      lnk_sck  = 1'b0;
      lnk_cs_n = 1'b1;
      lnk_si   = 1'b0;
   end
   // 8 MHz keeps well under every read clock limit
   task automatic send(input logic [15:0] frame, input int nbits);
      lnk_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         lnk_si = frame[15-i];
         #62.5 lnk_sck = 1'b1;
         #62.5 lnk_sck = 1'b0;
      end
      #62.5 lnk_cs_n = 1'b1;
      lnk_si = ~lnk_si;
      #250;
   endtask
endmodule

// ---- dv/test_flash_config_registers.sv ----
// Purpose: Self-checking bench of the flash configuration registers
// Assumes: Small block count, link frames from the host model
// Notes:   Waits of six cycles cover the link crossing latency
`timescale 1ns/10ps
module test_flash_config_registers;
   import fcr_pkg::*;
   logic ref_clk, rst_n, wp_n, swd, pbusy, ebusy, ireq, qpi, dtr;
   logic [1:0] irow;
   logic [3:0] bp, dum, deig;
   logic [7:0] rop, fc, rp, swdata, sw_data;
   logic [23:0] acur, anext;
   logic [6:0] bb;
   logic [2:0] plo, phi;
   logic sck, cs_n, si, grant, we_latch, dres, pany, swp;
   int num_errors = 0, num_checks = 0, sw_cnt = 0;
   logic [3:0] qd[4] = '{4'h6, 4'h4, 4'h8, 4'ha};
   logic [3:0] dd[4] = '{4'h4, 4'h4, 4'h8, 4'h4};
   logic [3:0] dx[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
   logic [7:0] v;

   fcr_host host (.lnk_sck(sck), .lnk_cs_n(cs_n), .lnk_si(si));
   fcr_top #(.BLOCKS(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .lnk_sck(sck), .lnk_cs_n(cs_n), .lnk_si(si), .wp_n(wp_n),
      .status_bp(bp), .status_write_disable(swd), .program_busy(pbusy),
      .erase_busy(ebusy), .ir_program_req(ireq), .ir_program_row(irow),
      .ir_program_grant(grant), .rd_opcode(rop), .qpi_mode(qpi),
      .dtr_mode(dtr), .addr_cur(acur), .dummy_cycles(dum),
      .addr_next(anext), .function_config(fc), .read_parameters(rp),
      .write_enable_latch(we_latch), .drive_eighths(deig),
      .drive_reserved(dres), .burst_bytes(bb), .prot_any(pany),
      .prot_lo(plo), .prot_hi(phi), .status_write_pulse(swp),
      .status_write_data(swdata));

   always #10 ref_clk = ~ref_clk;
   // Pulse lasts one cycle, so catch it on every edge
   always @(posedge ref_clk) if (swp === 1'b1) begin
      sw_cnt++;
      sw_data = swdata;
   end

   task automatic check(input logic [23:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, dat, input int nb);
      host.send({op, dat}, nb);
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait2();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] op, input logic q, d,
                     input logic [3:0] exp);
      @(posedge ref_clk);
      rop <= op;
      qpi <= q;
      dtr <= d;
      wait2();
      check(dum, exp);
   endtask

   initial begin
      #500us;
      num_errors++;
      stop_test();
   end
   initial begin
      {ref_clk, rst_n, swd, pbusy, ebusy, ireq, qpi, dtr} = '0;
      {wp_n, irow, bp, rop, acur} = {1'b1, 2'h0, 4'h2, 8'h03, 24'h0};
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait2();
      check(fc, 8'h00);
      check(rp, 8'he0);
      check(deig, 4'h4);
      check({pany, plo, phi}, 7'h77);
      for (int i = 0; i < 8; i++) begin
         v = {i[2:0], i[1:0], 1'b0, i[1:0]};
         cmd(8'hc0, v, 16);
         check(rp, v);
         check(bb, 7'h08 << i[1:0]);
         check({dres, deig}, {i[1:0] == 2'h0, dx[i]});
         rd(8'h03, 1'b0, 1'b0, 4'h0);
         rd(8'h0b, 1'b0, 1'b0, 4'h8);
         rd(8'h3b, 1'b0, 1'b0, 4'h8);
         rd(8'h0b, 1'b1, 1'b0, qd[i[1:0]]);
         rd(8'heb, 1'b0, 1'b0, qd[i[1:0]]);
         rd(8'hbb, 1'b0, 1'b0, dd[i[1:0]]);
         rd(8'heb, 1'b0, 1'b1, qd[i[1:0]] >> 1);
         rd(8'hbb, 1'b0, 1'b1, dd[i[1:0]] >> 1);
      end
      @(posedge ref_clk);
      acur <= 24'h00003f;
      wait2();
      check(anext, 24'h000040);
      cmd(8'hc0, 8'he4, 16);
      @(posedge ref_clk);
      acur <= 24'h000107;
      wait2();
      check(anext, 24'h000100);
      cmd(8'h42, 8'h12, 16);
      check(fc, 8'h00);
      cmd(8'h06, 8'h00, 8);
      cmd(8'h42, 8'h12, 16);
      check({we_latch, fc}, 9'h012);
      check({pany, plo, phi}, 7'h41);
      foreach (dd[r]) begin
         @(posedge ref_clk);
         irow <= r[1:0];
         ireq <= 1'b1;
         wait2();
         check(grant, r != 0);
      end
      @(posedge ref_clk);
      ireq <= 1'b0;
      cmd(8'h06, 8'h00, 8);
      cmd(8'h42, 8'h00, 16);
      check(fc, 8'h12);
      cmd(8'h06, 8'h00, 8);
      cmd(8'h42, 8'hff, 16);
      check(fc, 8'hf2);
      @(posedge ref_clk);
      pbusy <= 1'b1;
      cmd(8'h75, 8'h00, 8);
      check(fc, 8'hf6);
      cmd(8'h7a, 8'h00, 8);
      check(fc, 8'hf2);
      @(posedge ref_clk);
      {pbusy, ebusy} <= 2'b01;
      cmd(8'h75, 8'h00, 8);
      check(fc, 8'hfa);
      // Program inside an erase suspend: both flags, program resumes first
      @(posedge ref_clk);
      {pbusy, ebusy} <= 2'b10;
      cmd(8'h75, 8'h00, 8);
      check(fc, 8'hfe);
      cmd(8'h7a, 8'h00, 8);
      check(fc, 8'hfa);
      cmd(8'h7a, 8'h00, 8);
      check(fc, 8'hf2);
      cmd(8'h06, 8'h00, 8);
      cmd(8'h01, 8'h55, 16);
      check({sw_cnt[3:0], sw_data}, 12'h155);
      @(posedge ref_clk);
      {swd, wp_n} <= 2'b10;
      cmd(8'h06, 8'h00, 8);
      cmd(8'h01, 8'haa, 16);
      check({we_latch, sw_cnt[3:0]}, 5'h11);
      @(posedge ref_clk);
      wp_n <= 1'b1;
      cmd(8'h01, 8'h3c, 16);
      check({sw_cnt[3:0], sw_data}, 12'h23c);
      stop_test();
   end
endmodule
